// ==== ffp_blank_timer.sv ====
// Blanking timer started by a pulse, counted in tick enables
`timescale 1ns/1ns
`default_nettype none
module ffp_blank_timer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Control
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic [7:0] length,
    // Status
    output logic busy
);
    typedef struct packed {
        logic [7:0] remain;
    } ffp_blank_t;
    ffp_blank_t state_q; // Ticks left
    ffp_blank_t state_d; // Next count

    // Load, count down or abort
    always_comb
    begin
        state_d = state_q;
        if (abort)
            state_d.remain = 8'h00;
        else if (start)
            state_d.remain = length;
        else if (tick && state_q.remain != 8'h00)
            state_d.remain = state_q.remain - 8'h01;
    end

    // Count register
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    // Busy while ticks remain
    assign busy = (state_q.remain != 8'h00);
endmodule
`default_nettype wire

// ==== ffp_fast_fault.sv ====
// Category A fault supervisor: desaturation, overcurrent, enable
`timescale 1ns/1ns
`default_nettype none
module ffp_fast_fault (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // APB slave
    input wire ffp_pkg::ffp_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Asynchronous comparator and enable pins
    input wire ffp_pkg::ffp_pins_t pinsAsync,
    // Sequencer and mode, same clock
    input wire logic pwmOnCmd,
    input wire logic plateauActive,
    input wire logic configOpmode,
    // Pin and analog controls
    output logic desatPullDown,
    output logic desatClamp,
    output logic desatLevelSelect,
    output logic [1:0] overcurrentLevelSelect,
    // Turn-off requests and notification
    output logic safeTurnOff,
    output logic regularTurnOff,
    output logic deviceDisabled,
    output logic fastFaultOut_n
);
    import ffp_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic dsatLvl;
        logic clampEn;
        logic [1:0] ocpLvl;
        logic [7:0] dsatBlank;
        logic [7:0] ocpBlank;
        logic [2:0] err;
        logic disabled;
        logic faultOut;
        logic enPrev;
        logic pwmPrev;
        logic plateauPrev;
        logic safeOff;
        logic regOff;
        logic [31:0] rdata;
        logic [1:0] tickCnt;
    } ffp_state_t;
    ffp_state_t state_q; // Registered state
    ffp_state_t state_d; // Next state

    ffp_pins_t pinsSync; // Synchronised pins
    logic tick; // Blanking time base
    logic onStart; // Rising on command
    logic hardOffStart; // Hard turn-off begins
    logic dsatBusy; // Desaturation_sense_pin on blanking
    logic ocpBusy; // Overcurrent blanking
    logic offExtBusy; // Pull-down extension
    logic dsatFault; // Desaturation_sense_pin event
    logic ocpFault; // Overcurrent event
    logic enFault; // Enable invalidated
    logic anyFault; // Any event
    logic ocpStatus; // Masked comparator
    logic [4:0] statusVec; // Status word
    logic wrEn; // APB write strobe
    logic rdEn; // APB read strobe
    logic mapped; // Address decodes
    logic reactivate; // Reactivation request
    logic [2:0] errClr; // Flags to clear

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    ffp_sync #(
        .W(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .asyncIn(pinsAsync),
        .syncOut(pinsSync)
    );

    // ************************************************************
    // Blanking timers
    // ************************************************************
    assign tick = (state_q.tickCnt == 2'(TICK_CYCLES - 1));
    assign onStart = pwmOnCmd && !state_q.pwmPrev;
    assign hardOffStart = !pwmOnCmd
        && ((state_q.pwmPrev && !plateauActive)
        || (state_q.plateauPrev && !plateauActive));

    ffp_blank_timer u_dsat_blank (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(tick),
        .start(onStart),
        .abort(!pwmOnCmd),
        .length(state_q.dsatBlank),
        .busy(dsatBusy)
    );

    ffp_blank_timer u_ocp_blank (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(tick),
        .start(onStart),
        .abort(!pwmOnCmd),
        .length(state_q.ocpBlank),
        .busy(ocpBusy)
    );

    ffp_blank_timer u_off_ext (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(tick),
        .start(hardOffStart),
        .abort(onStart),
        .length(state_q.dsatBlank),
        .busy(offExtBusy)
    );

    // ************************************************************
    // Monitors
    // ************************************************************
    // desaturation_sense_pin only when on
    assign dsatFault = pwmOnCmd && !onStart && !dsatBusy
        && pinsSync.desatComparator && !state_q.disabled;
    assign ocpFault = pwmOnCmd && !onStart && !ocpBusy
        && pinsSync.overcurrentComparator && !state_q.disabled;
    assign enFault = state_q.enPrev && !pinsSync.enableValid;
    assign anyFault = dsatFault || ocpFault || enFault;
    assign ocpStatus = pinsSync.overcurrentComparator
        && !ocpBusy && !onStart;
    assign statusVec = {state_q.faultOut, state_q.disabled,
        pinsSync.enableValid, ocpStatus, pinsSync.desatComparator};

    // ************************************************************
    // APB decode
    // ************************************************************
    assign wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite;
    assign rdEn = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
    assign mapped = (apbReq.paddr == OFS_CTRL)
        || (apbReq.paddr == OFS_BLANK)
        || (apbReq.paddr == OFS_ERR)
        || (apbReq.paddr == OFS_STAT);
    assign reactivate = wrEn && (apbReq.paddr == OFS_CTRL)
        && apbReq.pwdata[CTRL_REACT];
    assign errClr = (wrEn && apbReq.paddr == OFS_ERR)
        ? apbReq.pwdata[2:0] : 3'h0;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        state_d = state_q;
        state_d.pwmPrev = pwmOnCmd;
        state_d.plateauPrev = plateauActive;
        state_d.enPrev = pinsSync.enableValid;
        state_d.tickCnt = tick ? 2'h0 : state_q.tickCnt + 2'h1;
        // Configuration writes
        if (wrEn && apbReq.paddr == OFS_CTRL)
        begin
            if (configOpmode)
                state_d.dsatLvl = apbReq.pwdata[CTRL_DSAT_LVL];
            state_d.clampEn = apbReq.pwdata[CTRL_CLAMP_EN];
            state_d.ocpLvl = apbReq.pwdata[CTRL_OCP_LVL +: 2];
        end
        // Blanking lengths
        if (wrEn && apbReq.paddr == OFS_BLANK)
        begin
            state_d.dsatBlank = apbReq.pwdata[7:0];
            state_d.ocpBlank = apbReq.pwdata[BLANK_OCP +: 8];
        end
        state_d.err = (state_q.err & ~errClr)
            | {enFault, ocpFault, dsatFault};
        if (reactivate && state_q.err == 3'h0)
        begin
            state_d.disabled = 1'b0;
            state_d.faultOut = 1'b0;
        end
        state_d.safeOff = dsatFault || ocpFault;
        state_d.regOff = enFault && !(dsatFault || ocpFault);
        if (anyFault)
        begin
            state_d.disabled = 1'b1;
            // notify on state transition
            // A fault landing on an accepted reactivation still notifies
            if (!state_q.disabled || (reactivate && state_q.err == 3'h0))
                state_d.faultOut = 1'b1;
        end
        // Read data capture in setup phase
        if (rdEn)
        begin
            state_d.rdata = 32'h0000_0000;
            unique case (apbReq.paddr)
                OFS_CTRL:
                begin
                    state_d.rdata[CTRL_DSAT_LVL] = state_q.dsatLvl;
                    state_d.rdata[CTRL_CLAMP_EN] = state_q.clampEn;
                    state_d.rdata[CTRL_OCP_LVL +: 2] = state_q.ocpLvl;
                end
                OFS_BLANK:
                begin
                    state_d.rdata[7:0] = state_q.dsatBlank;
                    state_d.rdata[BLANK_OCP +: 8] = state_q.ocpBlank;
                end
                OFS_ERR:
                    state_d.rdata[2:0] = state_q.err;
                OFS_STAT:
                    state_d.rdata[4:0] = statusVec;
                default:
                    state_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= '0;
            state_q.dsatBlank <= RST_DSAT_BLANK;
            state_q.ocpBlank <= RST_OCP_BLANK;
            state_q.ocpLvl <= RST_OCP_LVL;
        end
        else
            state_q <= state_d;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata = state_q.rdata;
    assign pready = 1'b1;
    assign pslverr = apbReq.psel && apbReq.penable && !mapped;
    assign desatPullDown = onStart || (pwmOnCmd && dsatBusy)
        || (!pwmOnCmd && (state_q.pwmPrev || plateauActive
        || hardOffStart || offExtBusy));
    assign desatClamp = state_q.clampEn && !pwmOnCmd;
    assign desatLevelSelect = state_q.dsatLvl;
    assign overcurrentLevelSelect = state_q.ocpLvl;
    assign safeTurnOff = state_q.safeOff;
    assign regularTurnOff = state_q.regOff;
    assign deviceDisabled = state_q.disabled;
    assign fastFaultOut_n = !state_q.faultOut;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_STAY_DISABLED: assert property (
        state_q.disabled && !reactivate |=> state_q.disabled)
        else $error("device left disabled state without reactivation");
    AST_DSAT_ONLY_ON: assert property (
        !pwmOnCmd && !state_q.err[ERR_DSAT] |=> !state_q.err[ERR_DSAT])
        else $error("desaturation_sense_pin flag set while off");
    AST_DSAT_STATUS: assert property (
        rdEn && apbReq.paddr == OFS_STAT
        |=> prdata[0] == $past(pinsSync.desatComparator))
        else $error("desaturation_sense_pin status read wrong");
    AST_DSAT_BLANK: assert property (
        onStart && state_q.dsatBlank != 8'h00 ##1 pwmOnCmd
        |-> desatPullDown && !dsatFault)
        else $error("desaturation_sense_pin pin not held low in blanking");
    AST_DSAT_REACT: assert property (
        dsatFault |=> state_q.err[ERR_DSAT] && safeTurnOff
        && deviceDisabled)
        else $error("desaturation_sense_pin fault reaction missing");
    AST_LVL_LOCK: assert property (
        wrEn && !configOpmode |=> $stable(desatLevelSelect))
        else $error("desaturation_sense_pin level changed outside config");
    AST_CLAMP: assert property (
        wrEn && apbReq.paddr == OFS_CTRL && apbReq.pwdata[CTRL_CLAMP_EN]
        ##1 !pwmOnCmd |-> desatClamp)
        else $error("clamp missing during off");
    AST_OCP_MASK: assert property (
        onStart && state_q.ocpBlank != 8'h00 ##1 pwmOnCmd
        |-> ocpBusy && !ocpStatus && !ocpFault)
        else $error("overcurrent seen during blanking");
    AST_EN_FAULT: assert property (
        enFault |=> state_q.err[ERR_EN] && deviceDisabled)
        else $error("enable fault not flagged");
    AST_ERR_STICKY: assert property (
        state_q.err[ERR_OCP] && !errClr[ERR_OCP]
        |=> state_q.err[ERR_OCP] [*1])
        else $error("overcurrent flag dropped without clear");
    AST_FLT_OUT: assert property (
        !fastFaultOut_n && !reactivate |=> !fastFaultOut_n)
        else $error("fault output released early");

    COV_DSAT: cover property (dsatFault ##1 !fastFaultOut_n);
    COV_OCP: cover property (ocpFault);
    COV_EN: cover property (enFault);
    COV_REACT: cover property (deviceDisabled ##1 !deviceDisabled);
endmodule
`default_nettype wire

// ==== ffp_pkg.sv ====
// Shared constants and types for the fast fault protection block
package ffp_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int BLANK_TICK_NS = 100;
    localparam int TICK_CYCLES = (BLANK_TICK_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BLANK = 8'h04;
    localparam logic [7:0] OFS_ERR = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_DSAT_LVL = 0;
    localparam int CTRL_CLAMP_EN = 1;
    localparam int CTRL_OCP_LVL = 2;
    localparam int CTRL_REACT = 4;
    localparam int BLANK_OCP = 8;
    localparam int ERR_DSAT = 0;
    localparam int ERR_OCP = 1;
    localparam int ERR_EN = 2;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_DSAT_BLANK = 8'h0A;
    localparam logic [7:0] RST_OCP_BLANK = 8'h0A;
    localparam logic [1:0] RST_OCP_LVL = 2'h0;
    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ffp_apb_req_t;
    typedef struct packed {
        logic desatComparator;
        logic overcurrentComparator;
        logic enableValid;
    } ffp_pins_t;
endpackage

// ==== ffp_switch_model.sv ====
// Behavioural power switch with desaturation and sense-resistor pins
`timescale 1ns/1ns
`default_nettype none
module ffp_switch_model (
    // Gate command and pin controls from the block
    input wire logic gateOn,
    input wire logic desatPullDown,
    input wire logic desatClamp,
    // Fault injection from the bench
    input wire logic shortCircuit,
    input wire logic overCurrent,
    input wire logic desatOpen,
    input wire logic senseOpen,
    input wire logic enableValid,
    // Comparator levels seen by the block
    output var ffp_pkg::ffp_pins_t pins
);
    import ffp_pkg::*;
    // ****************
    // Pin levels
    // ****************
    logic pinHeld; // Pin forced low by the block
    logic vceHigh; // Switch off or not saturated
    assign pinHeld = desatPullDown | desatClamp;
    assign vceHigh = !gateOn | shortCircuit | desatOpen;
    assign pins.desatComparator = vceHigh & !pinHeld;
    assign pins.overcurrentComparator = senseOpen | (gateOn & overCurrent);
    assign pins.enableValid = enableValid;
endmodule
`default_nettype wire

// ==== ffp_sync.sv ====
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none
module ffp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Levels
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } ffp_sync_t;
    ffp_sync_t state_q; // Both stages
    ffp_sync_t state_d; // Next stages

    // Shift chain
    always_comb
    begin
        state_d.first = asyncIn;
        state_d.second = state_q.first;
    end

    // Stage registers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign syncOut = state_q.second;
endmodule
`default_nettype wire

// ==== test_fast_fault_protection.sv ====
// Self-checking bench for the fast fault protection block
`timescale 1ns/1ns
`default_nettype none
module test_fast_fault_protection;
    import ffp_pkg::*;
    // ****************
    // Signals
    // ****************
    logic sys_clk = 1'b0; // 20 MHz clock
    logic resetn = 1'b0; // Active-low reset
    ffp_apb_req_t apbReq = '0; // APB request
    ffp_pins_t pins; // Comparator levels from the switch
    logic pwmOnCmd = 1'b0, plateauActive = 1'b0, configOpmode = 1'b0;
    logic shortCircuit = 1'b0, overCurrent = 1'b0; // Fault injection
    logic desatOpen = 1'b0, senseOpen = 1'b0, enableValid = 1'b1;
    logic [31:0] prdata, rdVal; // Read data, last value taken
    logic pready, pslverr, rdErr, desatPullDown, desatClamp;
    logic desatLevelSelect, safeTurnOff, regularTurnOff;
    logic deviceDisabled, fastFaultOut_n;
    logic [1:0] overcurrentLevelSelect;
    int errors = 0, check_count = 0, n;
    // Free-running clock
    always #25 sys_clk = ~sys_clk;
    // ****************
    // Instances
    // ****************
    ffp_fast_fault u_ffp_fast_fault (
        .sys_clk(sys_clk), .resetn(resetn), .apbReq(apbReq),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pinsAsync(pins), .pwmOnCmd(pwmOnCmd),
        .plateauActive(plateauActive), .configOpmode(configOpmode),
        .desatPullDown(desatPullDown), .desatClamp(desatClamp),
        .desatLevelSelect(desatLevelSelect),
        .overcurrentLevelSelect(overcurrentLevelSelect),
        .safeTurnOff(safeTurnOff), .regularTurnOff(regularTurnOff),
        .deviceDisabled(deviceDisabled), .fastFaultOut_n(fastFaultOut_n)
    );
    ffp_switch_model u_ffp_switch_model (
        .gateOn(pwmOnCmd), .desatPullDown(desatPullDown),
        .desatClamp(desatClamp), .shortCircuit(shortCircuit),
        .overCurrent(overCurrent), .desatOpen(desatOpen),
        .senseOpen(senseOpen), .enableValid(enableValid), .pins(pins)
    );
    // ****************
    // Tasks
    // ****************
    // Verdict and end of run
    task automatic stop_test();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Compare and count
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Let one edge pass, then sample settled outputs
    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask
    // One APB transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int k;
        @(posedge sys_clk);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= a;
        apbReq.pwdata <= wd;
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge sys_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        // Hung slave ends the run
        if (k >= 50)
        begin
            errors++;
            stop_test();
        end
        rdVal = prdata;
        rdErr = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    // Read and compare under a mask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input logic [31:0] m, input string what);
        apb(1'b0, a, '0);
        chk(what, exp & m, rdVal & m);
    endtask
    // Wait for shutdown, then check the turn-off kind
    task automatic wait_fault(input logic safe);
        n = 0;
        while (deviceDisabled !== 1'b1 && n < 400)
        begin
            settle();
            n++;
        end
        if (n >= 400)
        begin
            errors++;
            stop_test();
        end
        chk("safe off", 32'(safe), 32'(safeTurnOff));
        chk("regular off", 32'(!safe), 32'(regularTurnOff));
        chk("fault out", 1'b0, fastFaultOut_n);
    endtask
    // Sticky flags, refused and accepted reactivation
    task automatic recover(input logic [31:0] exp);
        repeat (40) settle();
        rd(OFS_ERR, exp, 32'h7, "sticky flags");
        apb(1'b1, OFS_CTRL, 32'h10);
        settle();
        chk("held off", 1'b1, deviceDisabled);
        chk("fault held", 1'b0, fastFaultOut_n);
        apb(1'b1, OFS_ERR, exp);
        rd(OFS_ERR, 32'h0, 32'h7, "cleared flags");
        apb(1'b1, OFS_CTRL, 32'h10);
        settle();
        chk("reactivated", 1'b0, deviceDisabled);
        chk("fault out idle", 1'b1, fastFaultOut_n);
    endtask
    // Turn on with injected pin faults, then recover
    task automatic on_fault(input logic [1:0] inj, input logic [31:0] exp);
        @(posedge sys_clk);
        pwmOnCmd <= 1'b1;
        {desatOpen, senseOpen} <= inj;
        wait_fault(1'b1);
        @(posedge sys_clk);
        pwmOnCmd <= 1'b0;
        {desatOpen, senseOpen} <= 2'b00;
        recover(exp);
    endtask
    // ****************
    // Sequence
    // ****************
    // Hang guard
    initial
    begin
        #2000000;
        errors++;
        stop_test();
    end
    initial
    begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        chk("reset fault out", 1'b1, fastFaultOut_n);
        rd(OFS_BLANK, 32'h0A0A, 32'hFFFF, "blank reset");
        rd(OFS_STAT, 32'h5, 32'hF, "stat reset");
        apb(1'b0, 8'h10, '0);
        chk("unmapped err", 1'b1, rdErr);
        chk("unmapped data", 32'h0, rdVal);
        // Threshold select locked outside configuration mode
        apb(1'b1, OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h0, 32'h1, "level locked");
        configOpmode <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h3);
        settle();
        chk("level pin", 1'b1, desatLevelSelect);
        chk("clamp pin", 1'b1, desatClamp);
        rd(OFS_STAT, 32'h4, 32'h5, "clamped status");
        // Every overcurrent level code
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, OFS_CTRL, 32'(i << CTRL_OCP_LVL));
            settle();
            chk("ocp level", 32'(i), 32'(overcurrentLevelSelect));
        end
        configOpmode <= 1'b0;
        apb(1'b1, OFS_BLANK, 32'h1406);
        // Clean on pulse, then off through the plateau
        @(posedge sys_clk);
        pwmOnCmd <= 1'b1;
        settle();
        chk("blank hold", 1'b1, desatPullDown);
        repeat (30) settle();
        chk("released", 1'b0, desatPullDown);
        @(posedge sys_clk);
        pwmOnCmd <= 1'b0;
        plateauActive <= 1'b1;
        repeat (6) settle();
        chk("plateau hold", 1'b1, desatPullDown);
        @(posedge sys_clk);
        plateauActive <= 1'b0;
        repeat (9) settle();
        chk("off extension", 1'b1, desatPullDown);
        repeat (30) settle();
        chk("pin released", 1'b0, desatPullDown);
        rd(OFS_STAT, 32'h5, 32'hF, "live comparator");
        rd(OFS_ERR, 32'h0, 32'h7, "off no fault");
        // Open desaturation pin, fault lands while the ocp monitor is still blanked
        on_fault(2'b10, 32'h1);
        chk("desaturation_sense_pin delay", 1'b1, 32'(n >= 10 && n <= 24));
        // Overcurrent masked during its blanking
        @(posedge sys_clk);
        pwmOnCmd <= 1'b1;
        overCurrent <= 1'b1;
        rd(OFS_STAT, 32'h4, 32'hE, "ocp masked");
        chk("ocp blanked", 1'b0, deviceDisabled);
        wait_fault(1'b1);
        @(posedge sys_clk);
        pwmOnCmd <= 1'b0;
        overCurrent <= 1'b0;
        recover(32'h2);
        on_fault(2'b01, 32'h2);
        // Enable goes invalid
        @(posedge sys_clk);
        enableValid <= 1'b0;
        wait_fault(1'b0);
        rd(OFS_STAT, 32'h8, 32'hC, "enable invalid");
        @(posedge sys_clk);
        enableValid <= 1'b1;
        recover(32'h4);
        rd(OFS_STAT, 32'h4, 32'h4, "enable valid");
        stop_test();
    end
endmodule
`default_nettype wire
